// ---- rtl/irb_pkg.sv ----
// shared constants and types of the time code generator
package irb_pkg;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned MS_NS         = 1_000_000;
  localparam int unsigned MS_CYC_DEF    = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned SLOT_MS       = 10;
  localparam int unsigned ZERO_MS       = 2;
  localparam int unsigned ONE_MS        = 5;
  localparam int unsigned MARK_MS       = 8;
  localparam int unsigned SLOTS_PER_SEC = 100;
  localparam int unsigned MARK_EVERY    = 10;
  localparam int unsigned SEC_PER_MIN   = 60;
  localparam int unsigned NUM_OUT       = 2;
  // register map (byte addresses)
  localparam logic [7:0] REG_CFG1  = 8'h00;
  localparam logic [7:0] REG_HOLD1 = 8'h04;
  localparam logic [7:0] REG_CFG2  = 8'h08;
  localparam logic [7:0] REG_HOLD2 = 8'h0C;
  localparam logic [7:0] REG_CTRL  = 8'h10;
  localparam logic [7:0] REG_STAT  = 8'h14;
  // fields
  localparam int unsigned CFG_BASE_LO   = 6;
  localparam int unsigned CFG_INV       = 4;
  localparam int unsigned CTRL_OUT2_EN  = 0;
  localparam int unsigned CTRL_STORE    = 1;
  localparam int unsigned CTRL_STORE_CH = 2;
  localparam int unsigned STAT_W        = 3;
  localparam int unsigned STAT_SYNC     = 6;
  localparam int unsigned STAT_VALID    = 7;
  // reset values and hold limits
  localparam logic [7:0] CFG_RST      = 8'h00;
  localparam logic [7:0] HOLD_RST     = 8'hFF;
  localparam logic [7:0] HOLD_MIN     = 8'h02;
  localparam logic [7:0] HOLD_ENDLESS = 8'hFF;
  // time word layout: {year, sod, day, hour, min, sec}, bcd except sod
  localparam int unsigned TW_SEC = 0;
  localparam int unsigned TW_MIN = 7;
  localparam int unsigned TW_HR  = 14;
  localparam int unsigned TW_DAY = 20;
  localparam int unsigned TW_SOD = 30;
  localparam int unsigned TW_YR  = 47;
  localparam int unsigned TW_W   = 55;
  // slot positions inside the frame
  localparam int unsigned FP_SEC = 1;
  localparam int unsigned FP_MIN = 10;
  localparam int unsigned FP_HR  = 20;
  localparam int unsigned FP_DAY = 30;
  localparam int unsigned FP_YR  = 50;
  localparam int unsigned FP_CTL = 60;
  localparam int unsigned FP_SOD = 80;
  localparam int unsigned GRP    = 5;

  typedef enum logic [1:0] {
    SYM_ZERO = 2'h0,
    SYM_ONE  = 2'h1,
    SYM_MARK = 2'h3
  } irb_sym_t;

  typedef enum logic [2:0] {
    FMT_B002  = 3'h0,
    FMT_B006  = 3'h1,
    FMT_B003  = 3'h2,
    FMT_B007  = 3'h3,
    FMT_IEEE  = 3'h4,
    FMT_AFNOR = 3'h5
  } irb_fmt_t;

  typedef enum logic [1:0] {
    TB_LOCAL   = 2'h0,
    TB_STD     = 2'h1,
    TB_UTC     = 2'h2,
    TB_LOC_ALT = 2'h3
  } irb_base_t;
endpackage : irb_pkg

// ---- rtl/irb_fifo2.sv ----
// two-entry valid/ready buffer with flush
`timescale 1ns/100ps
`default_nettype none
module irb_fifo2 #(
  parameter int unsigned W = 2
) (
  input  wire logic         sys_clk_i,
  input  wire logic         rst_i,
  input  wire logic         flush_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic [W-1:0]      out_data_o
);
  logic [W-1:0] mem_q [2];
  logic         wr_q;
  logic         rd_q;
  logic [1:0]   cnt_q;
  logic         push;
  logic         pop;

  assign in_ready_o  = (cnt_q != 2'h2);
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // flush drops both entries; a push in that cycle is lost on purpose
  always_ff @(posedge sys_clk_i) begin
    if (rst_i || flush_i) begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      if (push) wr_q <= ~wr_q;
      if (pop) rd_q <= ~rd_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (push) mem_q[wr_q] <= in_data_i;
  end

  a_fifo_bound: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    cnt_q <= 2'h2)
    else $error("buffer count above two");
  a_fifo_full: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (cnt_q == 2'h2 && !out_ready_i && !flush_i) |=> cnt_q == 2'h2)
    else $error("full buffer lost an entry");
endmodule : irb_fifo2
`default_nettype wire

// ---- rtl/irb_timecode_gen.sv ----
// pulse-width time code generator with two outputs
// Contract
// - one frame per second, carrying 74 information bits
// - every symbol sits in a fixed 10 ms slot on a regular grid
// - high time 2 ms for zero, 5 ms for one, 8 ms for marker
// - markers placed so receivers find the start of each second
// - 30 bcd time bits, 27 control bits, 17 binary second-of-day bits
// - 100 slots per second, unassigned slots send logical zero
// - config bit 4 inverts the output
// - low three config bits pick format; 110 and 111 act as ieee1344
// - b002 time, b006 plus year, b003 plus sod, b007 both
// - ieee1344 fills control bits with year and time offset
// - hold 2..255 minutes limits output after sync status c
// - hold of 255 sends whenever valid time exists
// - exit key stores the shown hold value in non-volatile memory
// - optional second output with its own config and hold
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module irb_timecode_gen
  import irb_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYC_DEF
) (
  input  wire logic            sys_clk_i,
  input  wire logic            rst_i,
  input  wire logic [7:0]      reg_addr_i,
  input  wire logic [31:0]     reg_wdata_i,
  input  wire logic            reg_we_i,
  input  wire logic            reg_re_i,
  output logic      [31:0]     reg_rdata_o,
  input  wire logic            pps_i,
  input  wire logic            sync_c_i,
  input  wire logic            time_valid_i,
  input  wire logic [TW_W-1:0] loc_time_i,
  input  wire logic [TW_W-1:0] std_time_i,
  input  wire logic [TW_W-1:0] utc_time_i,
  input  wire logic            ofs_neg_i,
  input  wire logic [3:0]      ofs_hours_i,
  input  wire logic            exit_key_i,
  output logic                 nv_store_o,
  output logic                 nv_chan_o,
  output logic      [7:0]      nv_hold_o,
  output logic                 first_timecode_output_o,
  output logic                 second_timecode_output_o
);
  localparam int unsigned MSW = $clog2(MS_CYCLES + 1);

  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  function automatic logic [7:0] clamp_hold(input logic [7:0] v);
    return (v < HOLD_MIN) ? HOLD_MIN : v;
  endfunction : clamp_hold

  function automatic logic is_marker(input logic [6:0] idx);
    return (idx == 7'h0) || (7'(idx % 7'(MARK_EVERY)) == 7'(MARK_EVERY - 1));
  endfunction : is_marker

  function automatic logic [3:0] sym_ms(input irb_sym_t s);
    unique case (s)
      SYM_ZERO: return 4'(ZERO_MS);
      SYM_ONE:  return 4'(ONE_MS);
      SYM_MARK: return 4'(MARK_MS);
      default:  return 4'(ZERO_MS);
    endcase
  endfunction : sym_ms

  function automatic logic [TW_W-1:0] pick_time(
    input logic [1:0]      base,
    input logic [TW_W-1:0] loc,
    input logic [TW_W-1:0] std,
    input logic [TW_W-1:0] utc
  );
    unique case (irb_base_t'(base))
      TB_STD:               return std;
      TB_UTC:               return utc;
      TB_LOCAL, TB_LOC_ALT: return loc;
    endcase
  endfunction : pick_time

  function automatic logic [SLOTS_PER_SEC-1:0] build_frame(
    input logic [TW_W-1:0] t,
    input logic [2:0]      fsel,
    input logic            neg,
    input logic [3:0]      ofs
  );
    logic [SLOTS_PER_SEC-1:0] f;
    logic [2:0]               fm;
    logic                     yr;
    logic                     sod;
    f   = '0;
    fm  = (fsel[2] && fsel[1]) ? FMT_IEEE : fsel;
    yr  = (fm == FMT_B006) || (fm == FMT_B007) || fm[2];
    sod = (fm == FMT_B003) || (fm == FMT_B007) || fm[2];
    // bcd groups skip one slot between nibbles
    f[FP_SEC +: 4]         = t[TW_SEC +: 4];
    f[FP_SEC + GRP +: 3]   = t[TW_SEC + 4 +: 3];
    f[FP_MIN +: 4]         = t[TW_MIN +: 4];
    f[FP_MIN + GRP +: 3]   = t[TW_MIN + 4 +: 3];
    f[FP_HR +: 4]          = t[TW_HR +: 4];
    f[FP_HR + GRP +: 2]    = t[TW_HR + 4 +: 2];
    f[FP_DAY +: 4]         = t[TW_DAY +: 4];
    f[FP_DAY + GRP +: 4]   = t[TW_DAY + 4 +: 4];
    f[FP_DAY + 2*GRP +: 2] = t[TW_DAY + 8 +: 2];
    if (yr) begin
      f[FP_YR +: 4]       = t[TW_YR +: 4];
      f[FP_YR + GRP +: 4] = t[TW_YR + 4 +: 4];
    end
    if (fm == FMT_IEEE) begin
      f[FP_CTL + 4]     = neg;
      f[FP_CTL + 5 +: 4] = ofs;
    end
    if (sod) begin
      f[FP_SOD +: 9]          = t[TW_SOD +: 9];
      f[FP_SOD + 2*GRP +: 8]  = t[TW_SOD + 9 +: 8];
    end
    return f;
  endfunction : build_frame

  // register file
  logic [7:0]         cfg_q  [NUM_OUT];
  logic [7:0]         hold_q [NUM_OUT];
  logic               out2_en_q;
  logic [NUM_OUT-1:0] cfg_wr;
  logic [NUM_OUT-1:0] hold_wr;
  logic               ctrl_wr;
  logic               store_req;
  logic [31:0]        rdata_q;
  logic [5:0]         stat;
  logic [NUM_OUT-1:0] tc;
  logic               nv_store_q;
  logic               nv_chan_q;
  logic [7:0]         nv_hold_q;
  logic               exit_d_q;

  assign cfg_wr    = {reg_we_i && reg_addr_i == REG_CFG2,
                      reg_we_i && reg_addr_i == REG_CFG1};
  assign hold_wr   = {reg_we_i && reg_addr_i == REG_HOLD2,
                      reg_we_i && reg_addr_i == REG_HOLD1};
  assign ctrl_wr   = reg_we_i && (reg_addr_i == REG_CTRL);
  // the key press stores channel one; software picks a channel by ctrl
  assign store_req = (ctrl_wr && reg_wdata_i[CTRL_STORE])
                     || (exit_key_i && !exit_d_q);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_OUT; i++) begin
        cfg_q[i]  <= CFG_RST;
        hold_q[i] <= HOLD_RST;
      end
      out2_en_q <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_OUT; i++) begin
        if (cfg_wr[i]) cfg_q[i] <= reg_wdata_i[7:0];
        if (hold_wr[i]) hold_q[i] <= clamp_hold(reg_wdata_i[7:0]);
      end
      if (ctrl_wr) out2_en_q <= reg_wdata_i[CTRL_OUT2_EN];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      exit_d_q   <= 1'b0;
      nv_store_q <= 1'b0;
      nv_chan_q  <= 1'b0;
      nv_hold_q  <= 8'h00;
    end else begin
      exit_d_q   <= exit_key_i;
      nv_store_q <= store_req;
      if (store_req) begin
        nv_chan_q <= ctrl_wr & reg_wdata_i[CTRL_STORE_CH];
        nv_hold_q <= hold_q[ctrl_wr & reg_wdata_i[CTRL_STORE_CH]];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || !reg_re_i) begin
      rdata_q <= '0;
    end else begin
      case (reg_addr_i)
        REG_CFG1:  rdata_q <= 32'(cfg_q[0]);
        REG_HOLD1: rdata_q <= 32'(hold_q[0]);
        REG_CFG2:  rdata_q <= 32'(cfg_q[1]);
        REG_HOLD2: rdata_q <= 32'(hold_q[1]);
        REG_CTRL:  rdata_q <= 32'(out2_en_q);
        REG_STAT:  rdata_q <= 32'({time_valid_i, sync_c_i, stat});
        default:   rdata_q <= '0;
      endcase
    end
  end

  assign reg_rdata_o              = rdata_q;
  assign nv_store_o               = nv_store_q;
  assign nv_chan_o                = nv_chan_q;
  assign nv_hold_o                = nv_hold_q;
  assign first_timecode_output_o  = tc[0];
  assign second_timecode_output_o = tc[1];

  // shared millisecond and slot grid, realigned by each second pulse
  logic [MSW-1:0] ms_cnt_q;
  logic [3:0]     slot_ms_q;
  logic [6:0]     slot_q;
  logic           ms_tick;
  logic           slot_end;
  logic           slot_start;
  logic           sec_start;

  assign ms_tick    = (ms_cnt_q == MSW'(MS_CYCLES - 1));
  assign slot_end   = ms_tick && (slot_ms_q == 4'(SLOT_MS - 1));
  assign slot_start = pps_i || slot_end;
  assign sec_start  = pps_i
                      || (slot_end && slot_q == 7'(SLOTS_PER_SEC - 1));

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || pps_i || ms_tick) ms_cnt_q <= '0;
    else ms_cnt_q <= ms_cnt_q + MSW'(1);
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || slot_start) slot_ms_q <= 4'h0;
    else if (ms_tick) slot_ms_q <= slot_ms_q + 4'h1;
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i || sec_start) slot_q <= 7'h0;
    else if (slot_end) slot_q <= slot_q + 7'h1;
  end

  a_sec_frame: assert property (sec_start |=>
    slot_q == 7'h0 && slot_ms_q == 4'h0 && ms_cnt_q == '0)
    else $error("second start did not realign the grid");
  a_slot_len: assert property ((slot_start && !pps_i) |->
    slot_ms_q == 4'(SLOT_MS - 1) && ms_tick)
    else $error("slot ended off the ten ms grid");
  a_slot_step: assert property ((slot_start && !sec_start) |=>
    slot_q == $past(slot_q) + 7'h1 && slot_q < 7'(SLOTS_PER_SEC))
    else $error("slot index skipped");

  for (genvar g = 0; g < NUM_OUT; g++) begin : g_ch
    logic [SLOTS_PER_SEC-1:0] frame_q;
    logic [6:0]               pidx_q;
    logic                     push_v;
    logic                     push_rdy;
    irb_sym_t                 push_sym;
    logic                     pop_v;
    logic [1:0]               pop_raw;
    irb_sym_t                 sym_q;
    logic                     hi;
    logic                     en;
    logic                     ch_on;
    logic                     tc_q;
    logic                     sync_d_q;
    logic                     reload;
    logic [7:0]               min_left_q;
    logic [5:0]               sec_q;
    logic                     armed_q;
    logic                     expired_q;
    logic [31:0]              hl_q;

    always_ff @(posedge sys_clk_i) begin
      if (rst_i) frame_q <= '0;
      else if (sec_start) frame_q <= build_frame(
        pick_time(cfg_q[g][CFG_BASE_LO +: 2], loc_time_i, std_time_i,
                  utc_time_i),
        cfg_q[g][2:0], ofs_neg_i, ofs_hours_i);
    end

    // slot 0 is forced at second start, so the producer restarts at 1
    always_ff @(posedge sys_clk_i) begin
      if (rst_i || sec_start) pidx_q <= 7'h1;
      else if (push_v && push_rdy) pidx_q <= pidx_q + 7'h1;
    end

    assign push_v   = (pidx_q < 7'(SLOTS_PER_SEC)) && !sec_start;
    assign push_sym = is_marker(pidx_q) ? SYM_MARK
                      : (frame_q[pidx_q] ? SYM_ONE : SYM_ZERO);

    irb_fifo2 #(.W(2)) u_buf (
      .sys_clk_i   (sys_clk_i),
      .rst_i       (rst_i),
      .flush_i     (sec_start),
      .in_valid_i  (push_v),
      .in_ready_o  (push_rdy),
      .in_data_i   (push_sym),
      .out_valid_o (pop_v),
      .out_ready_i (slot_start && !sec_start),
      .out_data_o  (pop_raw)
    );

    // an empty buffer at a slot start sends zero rather than stalling
    always_ff @(posedge sys_clk_i) begin
      if (rst_i) sym_q <= SYM_ZERO;
      else if (sec_start) sym_q <= SYM_MARK;
      else if (slot_start) sym_q <= pop_v ? irb_sym_t'(pop_raw) : SYM_ZERO;
    end

    assign hi    = slot_ms_q < sym_ms(sym_q);
    assign ch_on = (g == 0) || out2_en_q;
    assign en    = time_valid_i && ch_on
                   && (hold_q[g] == HOLD_ENDLESS || !expired_q);

    // idle level is the logical low of the chosen polarity
    always_ff @(posedge sys_clk_i) begin
      if (rst_i) tc_q <= 1'b0;
      else tc_q <= (en && hi) ^ cfg_q[g][CFG_INV];
    end
    assign tc[g] = tc_q;

    assign reload = (sync_c_i && !sync_d_q) || hold_wr[g];

    always_ff @(posedge sys_clk_i) begin
      if (rst_i) sync_d_q <= 1'b0;
      else sync_d_q <= sync_c_i;
    end

    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        min_left_q <= HOLD_RST;
        sec_q      <= 6'h0;
        armed_q    <= 1'b0;
        expired_q  <= 1'b0;
      end else if (reload) begin
        min_left_q <= hold_wr[g] ? clamp_hold(reg_wdata_i[7:0])
                                 : hold_q[g];
        sec_q      <= 6'h0;
        armed_q    <= sync_c_i;
        expired_q  <= 1'b0;
      end else if (armed_q && !expired_q && sec_start) begin
        if (sec_q == 6'(SEC_PER_MIN - 1)) begin
          sec_q      <= 6'h0;
          min_left_q <= min_left_q - 8'h1;
          if (min_left_q == 8'h1) expired_q <= 1'b1;
        end else begin
          sec_q <= sec_q + 6'h1;
        end
      end
    end

    assign stat[g*STAT_W +: STAT_W] = {expired_q, armed_q, en};

    always_ff @(posedge sys_clk_i) begin
      if (rst_i || slot_start) hl_q <= '0;
      else if (hi) hl_q <= hl_q + 32'h1;
    end

    sequence s_sec_begin;
      sec_start ##1 (en && !cfg_wr[g]);
    endsequence

    a_mark_out: assert property (s_sec_begin |=>
      tc_q == !cfg_q[g][CFG_INV])
      else $error("marker not high at second start");
    a_high_width: assert property ($fell(hi) && !slot_start |->
      hl_q == MS_CYCLES * 32'(sym_ms(sym_q)))
      else $error("symbol high time wrong");
    a_mark_pos: assert property ((slot_end && slot_q == 7'h8) |=>
      sym_q == SYM_MARK)
      else $error("marker missing before slot ten");
    a_fmt_plain: assert property ((sec_start && cfg_q[g][2:0] == FMT_B002)
      |=> frame_q[FP_YR +: 9] == '0 && frame_q[FP_SOD +: 18] == '0)
      else $error("time-only format carried extra fields");
    a_ieee_ctl: assert property ((sec_start && cfg_q[g][2]
      && (cfg_q[g][1] || !cfg_q[g][0])) |=>
      frame_q[FP_CTL + 4] == $past(ofs_neg_i)
      && frame_q[FP_CTL + 5 +: 4] == $past(ofs_hours_i))
      else $error("ieee control field wrong");
    a_time_base: assert property ((sec_start
      && cfg_q[g][CFG_BASE_LO +: 2] == TB_UTC) |=>
      frame_q[FP_SEC +: 4] == $past(utc_time_i[TW_SEC +: 4]))
      else $error("utc base not encoded");
    a_hold_reload: assert property (reload |=>
      !expired_q && sec_q == 6'h0 && min_left_q == hold_q[g])
      else $error("hold timer not reloaded");
    a_hold_expire: assert property ($rose(expired_q) |->
      $past(min_left_q) == 8'h1 && $past(armed_q) && !$past(reload))
      else $error("hold expired early");
    a_endless: assert property ((time_valid_i && ch_on
      && hold_q[g] == HOLD_ENDLESS) |-> en)
      else $error("endless hold stopped output");
  end

  a_nv_store: assert property ((ctrl_wr && reg_wdata_i[CTRL_STORE])
    |=> nv_store_o && nv_hold_o == $past(hold_q[reg_wdata_i[CTRL_STORE_CH]]))
    else $error("hold value not stored");
endmodule : irb_timecode_gen
`default_nettype wire

// ---- bench/irb_rx_model.sv ----
// receiver model: pulse-width decoder that rebuilds whole frames
`timescale 1ns/100ps
`default_nettype none
module irb_rx_model
  import irb_pkg::*;
#(
  parameter int unsigned MS = 10
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         line_i,
  input  wire logic         inv_i,
  output logic      [199:0] frame_o,
  output int                frames_o,
  output int                gaps_o
);
  logic         lvl_q;
  logic [1:0]   last_q;
  logic [1:0]   s;
  logic [199:0] fr_q;
  int           t_q, rise_q, prev_q, idx_q, w;
  always @(posedge clk_i) begin
    t_q++;
    if (rst_i) begin
      last_q = SYM_ZERO;
      idx_q = 0;
      frames_o = 0;
      gaps_o = 0;
    end else begin
      if ((line_i ^ inv_i) && !lvl_q)
        rise_q = t_q;
      w = t_q - rise_q;
      // blips from a polarity change are shorter than any symbol
      if (!(line_i ^ inv_i) && lvl_q && w >= MS) begin
        s = (2 * w < 7 * MS) ? SYM_ZERO :
            (2 * w < 13 * MS) ? SYM_ONE : SYM_MARK;
        // two markers in a row: the second one opens the frame
        if (s == SYM_MARK && last_q == SYM_MARK) begin
          idx_q = 1;
          fr_q[1:0] = s;
        end else if (idx_q > 0) begin
          if (rise_q - prev_q != 10 * MS)
            gaps_o++;
          fr_q[2*idx_q+:2] = s;
          idx_q++;
        end
        if (idx_q == 100) begin
          frame_o = fr_q;
          frames_o++;
          idx_q = 0;
        end
        last_q = s;
        prev_q = rise_q;
      end
    end
    lvl_q = line_i ^ inv_i;
  end
endmodule : irb_rx_model
`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking bench for the pulse-width time code generator
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import irb_pkg::*;
  localparam int unsigned MSC = 10;
  localparam int unsigned SEC = SLOTS_PER_SEC * SLOT_MS * MSC;
  localparam logic [7:0] C1 [4] = '{8'h00, 8'h44, 8'hC6, 8'h01};
  localparam logic [7:0] C2 [4] = '{8'h93, 8'h05, 8'h12, 8'h17};
  localparam int GP [9] = '{1, 6, 10, 15, 20, 25, 30, 35, 40};
  localparam int GB [9] = '{0, 4, 7, 11, 14, 18, 20, 24, 28};
  localparam int GN [9] = '{4, 3, 4, 3, 4, 2, 4, 4, 2};
  logic            sys_clk_i, rst_i, we, re, pps, sync_c, tvalid;
  logic            exit_key, mrst, inv1, inv2, store, chan, out1, out2;
  logic [7:0]      addr, hold;
  logic [31:0]     wdata, rdata, d;
  logic [TW_W-1:0] loc_t, std_t, utc_t;
  logic [199:0]    fr1, fr2;
  int              mismatches, tests_run, cyc, nfr1, nfr2, gap1, gap2;

  irb_timecode_gen #(.MS_CYCLES(MSC)) DUT (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_we_i(we), .reg_re_i(re),
    .reg_rdata_o(rdata), .pps_i(pps), .sync_c_i(sync_c),
    .time_valid_i(tvalid), .loc_time_i(loc_t), .std_time_i(std_t),
    .utc_time_i(utc_t), .ofs_neg_i(1'h1), .ofs_hours_i(4'h5),
    .exit_key_i(exit_key), .nv_store_o(store), .nv_chan_o(chan),
    .nv_hold_o(hold), .first_timecode_output_o(out1),
    .second_timecode_output_o(out2));
  irb_rx_model #(.MS(MSC)) rx1 (.clk_i(sys_clk_i), .rst_i(mrst),
    .line_i(out1), .inv_i(inv1), .frame_o(fr1), .frames_o(nfr1),
    .gaps_o(gap1));
  irb_rx_model #(.MS(MSC)) rx2 (.clk_i(sys_clk_i), .rst_i(mrst),
    .line_i(out2), .inv_i(inv2), .frame_o(fr2), .frames_o(nfr2),
    .gaps_o(gap2));

  task automatic results();
    if (mismatches == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results

  task automatic chk(input logic [199:0] got, input logic [199:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_i);
    we <= 1'h1;
    addr <= a;
    wdata <= v;
    @(posedge sys_clk_i);
    we <= 1'h0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk_i);
    re <= 1'h1;
    addr <= a;
    @(posedge sys_clk_i);
    re <= 1'h0;
    #1;
    v = rdata;
  endtask : rd

  // second start; c asks for the marker edge to be checked
  task automatic tick(input bit c);
    @(posedge sys_clk_i);
    pps <= 1'h1;
    @(posedge sys_clk_i);
    pps <= 1'h0;
    #1;
    if (c) chk({out2 ^ inv2, out1 ^ inv1}, 2'h0);
    @(posedge sys_clk_i);
    #1;
    if (c) chk({out2 ^ inv2, out1 ^ inv1}, 2'h3);
  endtask : tick

  task automatic setcfg(input int p);
    wr(REG_CFG1, {24'h0, C1[p]});
    wr(REG_CFG2, {24'h0, C2[p]});
    inv1 <= C1[p][CFG_INV];
    inv2 <= C2[p][CFG_INV];
  endtask : setcfg

  function automatic logic [TW_W-1:0] mk(input logic [5:0]  h,
                                         input logic [16:0] s);
    return {8'h24, s, 10'h123, h, 7'h34, 7'h56};
  endfunction : mk

  function automatic void put(inout logic [199:0] r,
    input logic [TW_W-1:0] t, input int p, input int b, input int n);
    for (int k = 0; k < n; k++) r[2*(p+k)+:2] = {1'h0, t[b+k]};
  endfunction : put

  function automatic logic [199:0] exp_fr(input logic [7:0] c);
    logic [199:0]    r;
    logic [TW_W-1:0] t;
    r = '0;
    t = c[7:6] == 2'h1 ? std_t : c[7:6] == 2'h2 ? utc_t : loc_t;
    for (int i = 0; i < 100; i++)
      if (i % 10 == 9 || i == 0) r[2*i+:2] = SYM_MARK;
    for (int g = 0; g < 9; g++) put(r, t, GP[g], GB[g], GN[g]);
    if (c[2:0] != 3'h0 && c[2:0] != 3'h2) begin
      put(r, t, 50, 47, 4);
      put(r, t, 55, 51, 4);
    end
    // every ieee variant and afnor also carry second of day
    if (c[2] || c[1]) begin
      put(r, t, 80, 30, 9);
      put(r, t, 90, 39, 8);
    end
    // offset sign then hours, lsb first
    if (c[2] && c[1:0] != 2'h1) put(r, TW_W'(9'h0B), 64, 0, 5);
    return r;
  endfunction : exp_fr

  initial begin
    sys_clk_i = 1'h0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  // runaway guard, well past the five seconds of traffic
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 7 * SEC) begin
      mismatches++;
      results();
    end
  end

  initial begin
    {we, re, pps, sync_c, tvalid, exit_key, inv1, inv2} = '0;
    {addr, wdata} = '0;
    mrst = 1'h1;
    rst_i = 1'h1;
    loc_t = mk(6'h12, 17'h0_B0F0);
    std_t = mk(6'h11, 17'h0_A2E0);
    utc_t = mk(6'h10, 17'h0_94D0);
    repeat (4) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    wr(REG_HOLD1, 32'h0000_0001);
    rd(REG_HOLD1, d);
    chk(d, 32'h0000_0002);
    wr(REG_HOLD1, 32'h0000_000A);
    rd(REG_HOLD1, d);
    chk(d, 32'h0000_000A);
    wr(REG_CTRL, 32'h0000_0003);
    chk({store, chan, hold}, 10'h20A);
    wr(REG_CTRL, 32'h0000_0007);
    chk({store, chan, hold}, 10'h3FF);
    rd(REG_CTRL, d);
    chk(d, 32'h0000_0001);
    wr(8'h18, 32'h0000_00FF);
    rd(8'h18, d);
    chk(d, 32'h0000_0000);
    @(posedge sys_clk_i);
    exit_key <= 1'h1;
    for (int i = 0; i < 4 && store !== 1'h1; i++) begin
      @(posedge sys_clk_i);
      #1;
    end
    chk({store, chan, hold}, 10'h20A);
    @(posedge sys_clk_i);
    exit_key <= 1'h0;
    tvalid <= 1'h1;
    sync_c <= 1'h1;
    rd(REG_STAT, d);
    chk(d & 32'h0000_00C9, 32'h0000_00C9);
    setcfg(0);
    tick(1'b0);
    mrst <= 1'h0;
    for (int p = 0; p < 5; p++) begin
      repeat (SEC - 13) @(posedge sys_clk_i);
      #1;
      if (p > 0) begin
        chk(fr1, exp_fr(C1[p-1]));
        chk(fr2, exp_fr(C2[p-1]));
      end
      if (p < 4) begin
        setcfg(p);
        repeat (6) @(posedge sys_clk_i);
        tick(1'b1);
      end
    end
    chk({gap2, gap1}, 64'h0);
    chk({nfr2, nfr1}, {32'h4, 32'h4});
    results();
  end
endmodule : tb_top
`default_nettype wire
